// ---- dsrs_pkg.sv ----
// Shared types and constants of the door state relay signalling block
package dsrs_pkg;

	// Drive order tracking, direction as the motor currently runs it
	typedef enum logic [1:0] {
		ORD_IDLE,
		ORD_CLOSING,
		ORD_OPENING
	} dsrs_order_t;

	// Encoding of the drive order direction input
	localparam logic DIR_OPEN         = 1'h1;
	localparam logic DIR_CLOSE        = 1'h0;

	// Sensor configuration setting: sensor function test selected
	localparam logic CFG_TEST_ON      = 1'h1;

	// Reset values
	localparam logic RST_CONTACT      = 1'h0;
	localparam logic RST_DOOR_STATE   = 1'h0;
	localparam logic RST_REVERSED     = 1'h0;
	localparam logic RST_SYNC         = 1'h0;
	localparam dsrs_order_t RST_ORDER = ORD_IDLE;

endpackage

// ---- dsrs_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps

module dsrs_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Asynchronous pin level
	input  wire logic din,
	// Level in the clock domain
	output logic      dout
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic out_ff;

	// The first stage feeds only the second; metastability settles there
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= dsrs_pkg::RST_SYNC;
			s2_ff <= dsrs_pkg::RST_SYNC;
			s3_ff <= dsrs_pkg::RST_SYNC;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A single-cycle glitch never reaches the output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_ff <= dsrs_pkg::RST_SYNC;
		end else if (s2_ff == s3_ff) begin
			out_ff <= s3_ff;
		end
	end

	assign dout = out_ff;

endmodule

// ---- dsrs_top.sv ----
// Door state relay signalling: closed, reversing and open contacts with fault encoding
`timescale 1ns/10ps

module dsrs_top (
	// Clock and reset
	input  wire logic CORE_CLK,
	input  wire logic RST,
	// Drive order events from the motor control logic
	input  wire logic ORDER_START,
	input  wire logic ORDER_DIR,
	input  wire logic ORDER_REVERSE,
	input  wire logic ORDER_DONE,
	input  wire logic ORDER_ABORT,
	// Door position sensor pins
	input  wire logic DOOR_AT_CLOSED,
	input  wire logic DOOR_AT_OPEN,
	// Sensor configuration and test stimulus
	input  wire logic SENSOR_CONFIGURATION_SETTING,
	input  wire logic SENSOR_TEST_STIMULUS,
	// System fault level
	input  wire logic SYSTEM_FAULT,
	// Relay contacts
	output logic      CLOSED_STATE_CONTACT,
	output logic      REVERSING_CONTACT,
	output logic      OPEN_STATE_CONTACT,
	// Order status
	output logic      ORDER_RUNNING
);

	dsrs_pkg::dsrs_order_t order_ff;
	dsrs_pkg::dsrs_order_t nxt_order;

	logic at_closed;
	logic at_open;
	logic at_closed_prev_ff;
	logic at_open_prev_ff;
	logic closed_fall;
	logic open_rise;
	logic open_fall;

	logic running;
	logic order_end;
	logic close_done;
	logic open_done;
	logic push_open;

	logic closed_ff;
	logic nxt_closed;
	logic open_ff;
	logic nxt_open;
	logic rev_ff;
	logic nxt_rev;

	logic closed_contact_ff;
	logic open_contact_ff;
	logic rev_contact_ff;

	// Position pins come from outside the clock domain
	dsrs_sync u_sync_closed (
		.clk  (CORE_CLK),
		.rst  (RST),
		.din  (DOOR_AT_CLOSED),
		.dout (at_closed)
	);

	dsrs_sync u_sync_open (
		.clk  (CORE_CLK),
		.rst  (RST),
		.din  (DOOR_AT_OPEN),
		.dout (at_open)
	);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			at_closed_prev_ff <= dsrs_pkg::RST_SYNC;
			at_open_prev_ff   <= dsrs_pkg::RST_SYNC;
		end else begin
			at_closed_prev_ff <= at_closed;
			at_open_prev_ff   <= at_open;
		end
	end

	assign closed_fall = at_closed_prev_ff & ~at_closed;
	assign open_rise   = ~at_open_prev_ff & at_open;
	assign open_fall   = at_open_prev_ff & ~at_open;

	// Drive order tracking
	assign running   = (order_ff != dsrs_pkg::ORD_IDLE);
	assign order_end = ORDER_DONE | ORDER_ABORT;

	always_comb begin
		nxt_order = order_ff;
		if (ORDER_START) begin
			nxt_order = (ORDER_DIR == dsrs_pkg::DIR_OPEN) ?
				dsrs_pkg::ORD_OPENING : dsrs_pkg::ORD_CLOSING;
		end else if (order_end) begin
			nxt_order = dsrs_pkg::ORD_IDLE;
		end else if (ORDER_REVERSE) begin
			unique case (order_ff)
				dsrs_pkg::ORD_IDLE:    nxt_order = dsrs_pkg::ORD_IDLE;
				dsrs_pkg::ORD_CLOSING: nxt_order = dsrs_pkg::ORD_OPENING;
				dsrs_pkg::ORD_OPENING: nxt_order = dsrs_pkg::ORD_CLOSING;
				default:               nxt_order = dsrs_pkg::ORD_IDLE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			order_ff <= dsrs_pkg::RST_ORDER;
		end else begin
			order_ff <= nxt_order;
		end
	end

	// A second reversal brings the order back to its own direction
	always_comb begin
		nxt_rev = rev_ff;
		if (ORDER_START || order_end) begin
			nxt_rev = 1'h0;
		end else if (ORDER_REVERSE && running) begin
			nxt_rev = ~rev_ff;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rev_ff <= dsrs_pkg::RST_REVERSED;
		end else begin
			rev_ff <= nxt_rev;
		end
	end

	// Completion only counts when the position sensor confirms the end stop
	assign close_done = ORDER_DONE & (order_ff == dsrs_pkg::ORD_CLOSING) & at_closed;
	assign open_done  = ORDER_DONE & (order_ff == dsrs_pkg::ORD_OPENING) & at_open;
	assign push_open  = open_rise & ~running & ~ORDER_START;

	// Closed state is logical, position alone never sets it
	always_comb begin
		nxt_closed = closed_ff;
		if (ORDER_START) begin
			nxt_closed = 1'h0;
		end else if (close_done) begin
			nxt_closed = 1'h1;
		end else if (closed_fall || open_done || push_open) begin
			nxt_closed = 1'h0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			closed_ff <= dsrs_pkg::RST_DOOR_STATE;
		end else begin
			closed_ff <= nxt_closed;
		end
	end

	always_comb begin
		nxt_open = open_ff;
		if (ORDER_START) begin
			nxt_open = 1'h0;
		end else if (open_done || push_open) begin
			nxt_open = 1'h1;
		end else if (open_fall || close_done) begin
			nxt_open = 1'h0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			open_ff <= dsrs_pkg::RST_DOOR_STATE;
		end else begin
			open_ff <= nxt_open;
		end
	end

	// Contact drivers; fault overrides the door states
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			closed_contact_ff <= dsrs_pkg::RST_CONTACT;
			open_contact_ff   <= dsrs_pkg::RST_CONTACT;
		end else if (SYSTEM_FAULT) begin
			closed_contact_ff <= 1'h1;
			open_contact_ff   <= 1'h1;
		end else begin
			closed_contact_ff <= closed_ff & ~open_ff;
			open_contact_ff   <= open_ff & ~closed_ff;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rev_contact_ff <= dsrs_pkg::RST_CONTACT;
		end else if (SENSOR_CONFIGURATION_SETTING == dsrs_pkg::CFG_TEST_ON) begin
			rev_contact_ff <= SENSOR_TEST_STIMULUS;
		end else begin
			rev_contact_ff <= rev_ff;
		end
	end

	assign CLOSED_STATE_CONTACT = closed_contact_ff;
	assign OPEN_STATE_CONTACT   = open_contact_ff;
	assign REVERSING_CONTACT    = rev_contact_ff;
	assign ORDER_RUNNING        = running;

	// Checks

	a_closed_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
		!SYSTEM_FAULT |=> (CLOSED_STATE_CONTACT == $past(closed_ff)))
		else $error("closed contact does not follow closed state");

	a_closed_cause: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(closed_ff) |-> $past(ORDER_DONE && order_ff == dsrs_pkg::ORD_CLOSING))
		else $error("closed state entered without completed closing order");

	a_no_push_close: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!closed_ff && !(ORDER_DONE && order_ff == dsrs_pkg::ORD_CLOSING)) |=> !closed_ff)
		else $error("closed state entered by pushing");

	a_start_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
		ORDER_START |=> (!closed_ff && !open_ff)
			##1 (CLOSED_STATE_CONTACT == $past(SYSTEM_FAULT)))
		else $error("new order did not leave door state");

	a_push_leaves: assert property (@(posedge CORE_CLK) disable iff (RST)
		(closed_ff && closed_fall && !close_done) |=> !closed_ff)
		else $error("closed state kept after door pushed away");

	a_rev_select: assert property (@(posedge CORE_CLK) disable iff (RST)
		(SENSOR_CONFIGURATION_SETTING != dsrs_pkg::CFG_TEST_ON)
			|=> (REVERSING_CONTACT == $past(rev_ff)))
		else $error("reversing contact not showing reversal");

	a_rev_toggle: assert property (@(posedge CORE_CLK) disable iff (RST)
		(ORDER_REVERSE && running && !ORDER_START && !order_end)
			|=> (rev_ff != $past(rev_ff)))
		else $error("reversal not registered");

	a_rev_ends: assert property (@(posedge CORE_CLK) disable iff (RST)
		(order_end || ORDER_START) |=> !rev_ff)
		else $error("reversal indication outlived its order");

	a_test_stim: assert property (@(posedge CORE_CLK) disable iff (RST)
		(SENSOR_CONFIGURATION_SETTING == dsrs_pkg::CFG_TEST_ON)
			|=> (REVERSING_CONTACT == $past(SENSOR_TEST_STIMULUS)))
		else $error("reversing contact not showing test stimulus");

	a_open_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
		!SYSTEM_FAULT |=> (OPEN_STATE_CONTACT == $past(open_ff)))
		else $error("open contact does not follow open state");

	a_open_entry: assert property (@(posedge CORE_CLK) disable iff (RST)
		(open_done || push_open) && !ORDER_START |=> open_ff ##1 (OPEN_STATE_CONTACT))
		else $error("open state not entered");

	a_fault_both: assert property (@(posedge CORE_CLK) disable iff (RST)
		SYSTEM_FAULT |=> (CLOSED_STATE_CONTACT && OPEN_STATE_CONTACT))
		else $error("fault not shown on both contacts");

	a_no_both: assert property (@(posedge CORE_CLK) disable iff (RST)
		!SYSTEM_FAULT |=> !(CLOSED_STATE_CONTACT && OPEN_STATE_CONTACT))
		else $error("both contacts active without fault");

	a_done_refused: assert property (@(posedge CORE_CLK) disable iff (RST)
		(ORDER_DONE && !at_closed && !closed_ff) |=> !closed_ff)
		else $error("closed state entered without end stop confirmation");

	a_run_start: assert property (@(posedge CORE_CLK) disable iff (RST)
		ORDER_START |=> ORDER_RUNNING)
		else $error("new order not tracked");

	a_run_end: assert property (@(posedge CORE_CLK) disable iff (RST)
		(order_end && !ORDER_START) |=> !ORDER_RUNNING)
		else $error("finished order still tracked");

	a_rev_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
		!ORDER_RUNNING |-> !rev_ff)
		else $error("reversal shown with no order running");

	a_open_leaves: assert property (@(posedge CORE_CLK) disable iff (RST)
		(open_ff && open_fall) |=> !open_ff)
		else $error("open state kept after door pushed away");

	a_open_cause: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(open_ff) |-> $past(open_done || push_open))
		else $error("open state entered without order or push");

	a_states_apart: assert property (@(posedge CORE_CLK) disable iff (RST)
		!(closed_ff && open_ff))
		else $error("closed and open states set together");

	a_close_clears_open: assert property (@(posedge CORE_CLK) disable iff (RST)
		close_done |=> !open_ff)
		else $error("open state kept after closing order completed");

endmodule

// ---- dsrs_ctrl_model.sv ----
// Higher-level controller model that decodes the relay contacts
`timescale 1ns/10ps

module dsrs_ctrl_model (
	// Relay contacts as read by the controller
	input  wire logic closed_contact,
	input  wire logic reversing_contact,
	input  wire logic open_contact,
	// Decoded door report
	output logic      door_closed,
	output logic      door_open,
	output logic      door_reversing,
	output logic      door_fault
);
	// Both contacts together is a fault, never a door state
	assign door_fault     = closed_contact & open_contact;
	assign door_closed    = closed_contact & ~open_contact;
	assign door_open      = open_contact & ~closed_contact;
	assign door_reversing = reversing_contact;
endmodule

// ---- dsrs_top_tb.sv ----
// Self-checking testbench of the door state relay signalling block
`timescale 1ns/10ps

module dsrs_top_tb;
	logic core_clk, rst, start, dir, rev, done, abort, at_closed, at_open;
	logic cfg, stim, fault, c_cl, c_rv, c_op, running, prev_fault;
	logic m_cl, m_op, m_rv, m_flt;
	int   fail_count = 0;
	int   n_tests    = 0;

	dsrs_top i_dsrs_top (
		.CORE_CLK                    (core_clk),
		.RST                         (rst),
		.ORDER_START                 (start),
		.ORDER_DIR                   (dir),
		.ORDER_REVERSE               (rev),
		.ORDER_DONE                  (done),
		.ORDER_ABORT                 (abort),
		.DOOR_AT_CLOSED              (at_closed),
		.DOOR_AT_OPEN                (at_open),
		.SENSOR_CONFIGURATION_SETTING(cfg),
		.SENSOR_TEST_STIMULUS        (stim),
		.SYSTEM_FAULT                (fault),
		.CLOSED_STATE_CONTACT        (c_cl),
		.REVERSING_CONTACT           (c_rv),
		.OPEN_STATE_CONTACT          (c_op),
		.ORDER_RUNNING               (running)
	);

	dsrs_ctrl_model i_dsrs_ctrl_model (
		.closed_contact   (c_cl),
		.reversing_contact(c_rv),
		.open_contact     (c_op),
		.door_closed      (m_cl),
		.door_open        (m_op),
		.door_reversing   (m_rv),
		.door_fault       (m_flt)
	);

	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask

	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
	endtask

	task automatic complete_run;
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Contacts lag the fault input by one edge, so compare with the fault seen then
	always @(posedge core_clk) prev_fault <= fault;
	always @(negedge core_clk) begin
		if (!rst && c_cl === 1'h1 && c_op === 1'h1) begin
			check({3'h0, prev_fault}, 4'h1);
		end
	end

	task automatic close_by_order;
		dir = dsrs_pkg::DIR_CLOSE;
		pulse(start);
		at_closed = 1'h1;
		cyc(6);
		check({c_cl, c_rv, c_op, running}, 4'h1);
		pulse(done);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h8);
		at_closed = 1'h0;
		cyc(8);
		check({c_cl, c_rv, c_op, running}, 4'h0);
	endtask

	task automatic push_closed;
		at_closed = 1'h1;
		cyc(8);
		check({c_cl, c_rv, c_op, running}, 4'h0);
		at_closed = 1'h0;
		cyc(8);
	endtask

	task automatic push_open_then_order;
		at_open = 1'h1;
		cyc(8);
		check({c_cl, c_rv, c_op, running}, 4'h2);
		check({m_cl, m_rv, m_op, m_flt}, 4'h2);
		dir = dsrs_pkg::DIR_CLOSE;
		pulse(start);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h1);
		pulse(abort);
		at_open = 1'h0;
		cyc(8);
		check({c_cl, c_rv, c_op, running}, 4'h0);
	endtask

	task automatic reversed_order;
		dir = dsrs_pkg::DIR_OPEN;
		pulse(start);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h1);
		pulse(rev);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h5);
		pulse(abort);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h0);
	endtask

	task automatic sensor_test_mode;
		cfg  = dsrs_pkg::CFG_TEST_ON;
		stim = 1'h1;
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h4);
		stim = 1'h0;
		dir  = dsrs_pkg::DIR_OPEN;
		pulse(start);
		pulse(rev);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h1);
		cfg = ~dsrs_pkg::CFG_TEST_ON;
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h5);
		pulse(abort);
		cyc(2);
	endtask

	task automatic order_checks;
		dir = dsrs_pkg::DIR_CLOSE;
		pulse(start);
		pulse(done);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h0);
		dir = dsrs_pkg::DIR_OPEN;
		pulse(start);
		pulse(rev);
		cyc(1);
		check({c_cl, c_rv, c_op, running}, 4'h5);
		pulse(rev);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h1);
		at_open = 1'h1;
		cyc(6);
		check({c_cl, c_rv, c_op, running}, 4'h1);
		pulse(done);
		cyc(2);
		check({c_cl, c_rv, c_op, running}, 4'h2);
		at_open = 1'h0;
		cyc(8);
		check({c_cl, c_rv, c_op, running}, 4'h0);
	endtask

	task automatic fault_report;
		fault = 1'h1;
		cyc(2);
		check({c_cl, c_op, m_flt, m_cl}, 4'hE);
		fault = 1'h0;
		cyc(2);
		check({c_cl, c_op, m_flt, m_cl}, 4'h0);
	endtask

	initial begin
		{start, dir, rev, done, abort, at_closed, at_open, cfg, stim, fault} = 10'h000;
		rst = 1'h1;
		repeat (16) @(posedge core_clk);
		#5;
		rst = 1'h0;
		cyc(4);
		close_by_order();
		push_closed();
		push_open_then_order();
		reversed_order();
		sensor_test_mode();
		order_checks();
		fault_report();
		complete_run();
	end

	// Scenarios need about 125 cycles; the limit of 3000 cycles leaves wide margin
	initial begin
		#(50 * 3000);
		fail_count++;
		complete_run();
	end
endmodule
